// >>> rtl/cba_defines.svh
`ifndef CBA_DEFINES_SVH
`define CBA_DEFINES_SVH
// condition code register address and flag bit positions
`define CBA_CC_ADDR 8'h00_D5
`define CBA_FLAG_C 7
`define CBA_FLAG_Z 6
`define CBA_FLAG_S 5
`define CBA_FLAG_V 4
`define CBA_FLAG_D 3
`define CBA_FLAG_H 2
`define CBA_CC_RESET 8'h00_00
// opcodes
`define CBA_OP_CARRY_TOGGLE 8'h00_EF
`define CBA_OP_ZFILL_R 8'h00_B0
`define CBA_OP_ZFILL_IR 8'h00_B1
`define CBA_OP_INV_R 8'h00_60
`define CBA_OP_INV_IR 8'h00_61
`define CBA_OP_CMP_RR 8'h00_A2
`define CBA_OP_CMP_RIR 8'h00_A3
`define CBA_OP_CMP_GG 8'h00_A4
`define CBA_OP_CMP_GIR 8'h00_A5
`define CBA_OP_CMP_IM 8'h00_A6
`define CBA_OP_MATCH_BR 8'h00_C2
`define CBA_OP_MISMATCH_BR 8'h00_D2
`define CBA_OP_BCD_R 8'h00_40
`define CBA_OP_BCD_IR 8'h00_41
// cycle counts
`define CBA_CYC_SHORT 5'd4
`define CBA_CYC_MED 5'd6
`define CBA_CYC_BR_TAKEN 5'd18
`define CBA_CYC_BR_NOT 5'd16
// working register bank base
`define CBA_WORK_BASE 8'h00_C0
`endif

// >>> rtl/cba_pkg.sv
package cba_pkg;
	typedef enum logic [2:0] {
		CBA_IDLE,
		CBA_PTR,
		CBA_READ,
		CBA_EXEC,
		CBA_WAIT
	} cba_state_e;
endpackage

// >>> rtl/cba_regfile_if.sv
interface cba_regfile_if;
	logic [7:0] ra;
	logic [7:0] rd;
	logic we;
	logic [7:0] wa;
	logic [7:0] wd;
	modport core (output ra, input rd, output we, output wa, output wd);
	modport mem (input ra, output rd, input we, input wa, input wd);
endinterface

// >>> rtl/cba_regfile.sv
module cba_regfile (
	input wire logic CLOCK,
	cba_regfile_if.mem rf
);
	logic [7:0] mem [0:255];
	logic [7:0] rdata;

	// synchronous write, registered read
	always_ff @(posedge CLOCK) begin
		if (rf.we) begin
			mem[rf.wa] <= rf.wd;
		end
		rdata <= mem[rf.ra];
	end

	assign rf.rd = rdata;
endmodule

// >>> rtl/cba_exec.sv
`include "cba_defines.svh"
// Notes on behaviour
// - EF toggles carry only, four cycles
// - carry lives in flag register D5
// - B0/B1 write zero, flags untouched
// - 60/61 write one's complement
// - invert: Z,S from result, V cleared
// - compare writes no operand back
// - compare sets C,Z,S,V from difference
// - compare opcodes A2..A6 with cycle counts
// - C2 branches when operands equal
// - step-branch bumps pointer, no flag change
// - D2 branches when operands differ
// - step-branch: 18 taken, 16 not
// - after add, add 00/06/60/66
// - after subtract, add 00/FA/A0/9A
// - 40/41 adjust: C,Z,S set, V undefined
// - pointer mode reads address from register
module cba_exec (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic START,
	input wire logic [7:0] OPCODE,
	input wire logic [7:0] OPERAND1,
	input wire logic [7:0] OPERAND2,
	input wire logic [7:0] OPERAND3,
	input wire logic [15:0] PC_NEXT,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic BUSY,
	output logic DONE,
	output logic PC_LOAD,
	output logic [15:0] PC_VALUE,
	output logic ILLEGAL,
	output logic [7:0] FLAGS_OUT
);
	cba_regfile_if rf ();

	cba_regfile u_regfile (
		.CLOCK(CLOCK),
		.rf(rf)
	);

	cba_pkg::cba_state_e state, next_state;
	logic [7:0] flags, next_flags;
	logic [7:0] op, next_op;
	logic [7:0] dst_addr, next_dst_addr;
	logic [7:0] src_addr, next_src_addr;
	logic [7:0] ptr_addr, next_ptr_addr;
	logic [7:0] dst_val, next_dst_val;
	logic [7:0] rel, next_rel;
	logic [7:0] imm, next_imm;
	logic [1:0] phase, next_phase;
	logic [4:0] cnt, next_cnt;
	logic [15:0] pc_base, next_pc_base;
	logic busy, next_busy;
	logic done, next_done;
	logic pc_load, next_pc_load;
	logic [15:0] pc_value, next_pc_value;
	logic illegal, next_illegal;
	logic [7:0] rdata, next_rdata;
	logic rd_pend, next_rd_pend;
	logic [3:0] op_src_reg, next_op_src_reg;
	logic [7:0] ra;
	logic we;
	logic [7:0] wa;
	logic [7:0] wd;

	// 4-bit working register number into the working bank
	function automatic logic [7:0] work_addr(input logic [3:0] r);
		work_addr = `CBA_WORK_BASE | {4'h0, r};
	endfunction

	// does this opcode take a pointer-mode operand
	function automatic logic uses_ptr(input logic [7:0] o);
		uses_ptr = (o == `CBA_OP_ZFILL_IR) || (o == `CBA_OP_INV_IR) ||
			(o == `CBA_OP_CMP_RIR) || (o == `CBA_OP_CMP_GIR) ||
			(o == `CBA_OP_BCD_IR) || (o == `CBA_OP_MATCH_BR) ||
			(o == `CBA_OP_MISMATCH_BR);
	endfunction

	// z and s from a result byte
	function automatic logic [1:0] zs(input logic [7:0] v);
		zs = {v == 8'h00, v[7]};
	endfunction

	// decimal adjust: {carry, result}
	function automatic logic [8:0] bcd_fix(input logic [7:0] v, input logic c,
		input logic h, input logic sub);
		logic [7:0] corr;
		logic cout;
		corr = 8'h00;
		cout = 1'b0;
		if (!sub) begin
			if (c || v[7:4] > 4'h9 || (v[7:4] == 4'h9 && v[3:0] > 4'h9)) begin
				cout = 1'b1;
			end
			if (h || v[3:0] > 4'h9) begin
				corr = cout ? 8'h66 : 8'h06;
			end else begin
				corr = cout ? 8'h60 : 8'h00;
			end
		end else begin
			cout = c;
			if (h) begin
				corr = c ? 8'h9A : 8'hFA;
			end else begin
				corr = c ? 8'hA0 : 8'h00;
			end
		end
		bcd_fix = {cout, 8'(v + corr)};
	endfunction

	// read port: flag register captured on the strobe edge, file data from its read register
	always_comb begin
		next_rd_pend = REG_RD && (REG_ADDR == `CBA_CC_ADDR);
		next_rdata = rdata;
		if (REG_RD && (REG_ADDR == `CBA_CC_ADDR)) begin
			next_rdata = flags;
		end
	end

	// sequencer and datapath next state
	always_comb begin
		logic [8:0] diff;
		logic [8:0] adj;
		logic [7:0] src_val;
		logic eq;
		diff = 9'h000;
		adj = 9'h000;
		src_val = 8'h00;
		eq = 1'b0;
		next_state = state;
		next_flags = flags;
		next_op = op;
		next_dst_addr = dst_addr;
		next_src_addr = src_addr;
		next_ptr_addr = ptr_addr;
		next_dst_val = dst_val;
		next_rel = rel;
		next_imm = imm;
		next_phase = phase;
		next_cnt = cnt;
		next_pc_base = pc_base;
		next_busy = busy;
		next_done = 1'b0;
		next_pc_load = 1'b0;
		next_pc_value = pc_value;
		next_illegal = 1'b0;
		ra = REG_ADDR;
		we = 1'b0;
		wa = REG_ADDR;
		wd = REG_WDATA;
		// software write to the flag register, or to the file
		if (REG_WR && state == cba_pkg::CBA_IDLE) begin
			if (REG_ADDR == `CBA_CC_ADDR) begin
				next_flags = REG_WDATA;
			end else begin
				we = 1'b1;
			end
		end
		if (cnt != 5'd0) begin
			next_cnt = 5'(cnt - 5'd1);
		end
		unique case (state)
			cba_pkg::CBA_IDLE: begin
				if (START) begin
					next_op = OPCODE;
					next_pc_base = PC_NEXT;
					next_busy = 1'b1;
					next_phase = 2'd1;
					next_imm = OPERAND2;
					next_rel = OPERAND3;
					next_cnt = `CBA_CYC_SHORT - 5'd1;
					next_state = cba_pkg::CBA_READ;
					case (OPCODE)
						`CBA_OP_CARRY_TOGGLE: begin
							next_flags[`CBA_FLAG_C] = ~flags[`CBA_FLAG_C];
							next_state = cba_pkg::CBA_WAIT;
						end
						`CBA_OP_CMP_RR, `CBA_OP_CMP_RIR: begin
							next_dst_addr = work_addr(OPERAND1[7:4]);
							next_src_addr = work_addr(OPERAND1[3:0]);
							if (OPCODE == `CBA_OP_CMP_RIR) begin
								next_cnt = `CBA_CYC_MED - 5'd1;
							end
						end
						`CBA_OP_CMP_GG, `CBA_OP_CMP_GIR: begin
							next_src_addr = OPERAND1;
							next_dst_addr = OPERAND2;
							next_cnt = `CBA_CYC_MED - 5'd1;
						end
						`CBA_OP_CMP_IM: begin
							next_dst_addr = OPERAND1;
							next_cnt = `CBA_CYC_MED - 5'd1;
						end
						`CBA_OP_MATCH_BR, `CBA_OP_MISMATCH_BR: begin
							next_src_addr = work_addr(OPERAND1[7:4]);
							next_dst_addr = work_addr(OPERAND1[3:0]);
							next_rel = OPERAND2;
							next_cnt = `CBA_CYC_BR_NOT - 5'd1;
						end
						`CBA_OP_ZFILL_R, `CBA_OP_ZFILL_IR, `CBA_OP_INV_R, `CBA_OP_INV_IR,
						`CBA_OP_BCD_R, `CBA_OP_BCD_IR: begin
							next_dst_addr = OPERAND1;
						end
						default: begin
							next_illegal = 1'b1;
							next_busy = 1'b0;
							next_done = 1'b1;
							next_state = cba_pkg::CBA_IDLE;
						end
					endcase
					// first read goes out on the start edge to save a cycle
					ra = next_dst_addr;
					if (uses_ptr(OPCODE)) begin
						next_state = cba_pkg::CBA_PTR;
						if (!(OPCODE inside {`CBA_OP_ZFILL_IR, `CBA_OP_INV_IR,
							`CBA_OP_BCD_IR})) begin
							ra = next_src_addr;
						end
					end
				end
			end
			cba_pkg::CBA_PTR: begin
				// pointer contents arrive; single-operand forms read the operand they name at once, two-operand forms read the destination first
				next_ptr_addr = rf.rd;
				next_phase = 2'd1;
				next_state = cba_pkg::CBA_READ;
				if (op inside {`CBA_OP_ZFILL_IR, `CBA_OP_INV_IR, `CBA_OP_BCD_IR}) begin
					next_dst_addr = rf.rd;
					ra = rf.rd;
				end else begin
					next_src_addr = rf.rd;
					ra = dst_addr;
				end
			end
			cba_pkg::CBA_READ: begin
				// destination data arrives, source read held until execute
				ra = src_addr;
				next_phase = 2'(phase + 2'd1);
				if (phase == 2'd1) begin
					next_dst_val = rf.rd;
					if (op inside {`CBA_OP_ZFILL_R, `CBA_OP_ZFILL_IR, `CBA_OP_INV_R,
						`CBA_OP_INV_IR, `CBA_OP_BCD_R, `CBA_OP_BCD_IR, `CBA_OP_CMP_IM}) begin
						next_state = cba_pkg::CBA_EXEC;
					end
				end
				if (phase == 2'd2) begin
					next_state = cba_pkg::CBA_EXEC;
				end
			end
			cba_pkg::CBA_EXEC: begin
				src_val = (op == `CBA_OP_CMP_IM) ? imm : rf.rd;
				diff = {1'b0, dst_val} - {1'b0, src_val};
				eq = (dst_val == src_val);
				next_state = cba_pkg::CBA_WAIT;
				// short pointer forms and the A2 register compare already used up their cycles
				if (cnt <= 5'd1) begin
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = cba_pkg::CBA_IDLE;
				end
				case (op)
					`CBA_OP_ZFILL_R, `CBA_OP_ZFILL_IR: begin
						we = 1'b1;
						wa = dst_addr;
						wd = 8'h00;
					end
					`CBA_OP_INV_R, `CBA_OP_INV_IR: begin
						we = 1'b1;
						wa = dst_addr;
						wd = ~dst_val;
						{next_flags[`CBA_FLAG_Z], next_flags[`CBA_FLAG_S]} = zs(~dst_val);
						next_flags[`CBA_FLAG_V] = 1'b0;
					end
					`CBA_OP_BCD_R, `CBA_OP_BCD_IR: begin
						adj = bcd_fix(dst_val, flags[`CBA_FLAG_C], flags[`CBA_FLAG_H],
							flags[`CBA_FLAG_D]);
						we = 1'b1;
						wa = dst_addr;
						wd = adj[7:0];
						next_flags[`CBA_FLAG_C] = adj[8];
						{next_flags[`CBA_FLAG_Z], next_flags[`CBA_FLAG_S]} = zs(adj[7:0]);
					end
					`CBA_OP_MATCH_BR, `CBA_OP_MISMATCH_BR: begin
						// pointer bumps either way, flags kept
						we = 1'b1;
						wa = work_addr(op_src_reg);
						wd = 8'(ptr_addr + 8'h01);
						if ((op == `CBA_OP_MATCH_BR) == eq) begin
							next_pc_value = 16'(pc_base + {{8{rel[7]}}, rel});
							next_cnt = 5'(cnt + `CBA_CYC_BR_TAKEN - `CBA_CYC_BR_NOT - 5'd1);
							next_pc_load = 1'b1;
						end
					end
					default: begin
						// compare: flags only, nothing written back
						next_flags[`CBA_FLAG_C] = diff[8];
						{next_flags[`CBA_FLAG_Z], next_flags[`CBA_FLAG_S]} = zs(diff[7:0]);
						next_flags[`CBA_FLAG_V] = (dst_val[7] != src_val[7]) &&
							(diff[7] != dst_val[7]);
					end
				endcase
			end
			cba_pkg::CBA_WAIT: begin
				// hold until the documented cycle count elapses
				if (cnt <= 5'd1) begin
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = cba_pkg::CBA_IDLE;
				end
			end
		endcase
	end

	// remember the source pointer register number for the step
	always_comb begin
		next_op_src_reg = op_src_reg;
		if (state == cba_pkg::CBA_IDLE && START) begin
			next_op_src_reg = OPERAND1[7:4];
		end
	end

	assign rf.ra = ra;
	assign rf.we = we;
	assign rf.wa = wa;
	assign rf.wd = wd;

	// register all state; unlisted flags simply carry over
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= cba_pkg::CBA_IDLE;
			flags <= `CBA_CC_RESET;
			op <= 8'h00;
			dst_addr <= 8'h00;
			src_addr <= 8'h00;
			ptr_addr <= 8'h00;
			dst_val <= 8'h00;
			rel <= 8'h00;
			imm <= 8'h00;
			phase <= 2'd0;
			cnt <= 5'd0;
			pc_base <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
			illegal <= 1'b0;
			rdata <= 8'h00;
			rd_pend <= 1'b0;
			op_src_reg <= 4'h0;
		end else begin
			state <= next_state;
			flags <= next_flags;
			op <= next_op;
			dst_addr <= next_dst_addr;
			src_addr <= next_src_addr;
			ptr_addr <= next_ptr_addr;
			dst_val <= next_dst_val;
			rel <= next_rel;
			imm <= next_imm;
			phase <= next_phase;
			cnt <= next_cnt;
			pc_base <= next_pc_base;
			busy <= next_busy;
			done <= next_done;
			pc_load <= next_pc_load;
			pc_value <= next_pc_value;
			illegal <= next_illegal;
			rdata <= next_rdata;
			rd_pend <= next_rd_pend;
			op_src_reg <= next_op_src_reg;
		end
	end

	assign REG_RDATA = rd_pend ? rdata : rf.rd;
	assign BUSY = busy;
	assign DONE = done;
	assign PC_LOAD = pc_load;
	assign PC_VALUE = pc_value;
	assign ILLEGAL = illegal;
	assign FLAGS_OUT = flags;
endmodule

// >>> verification/cba_exec_asserts.sv
module cba_exec_asserts (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic START,
	input wire logic [7:0] OPCODE,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic REG_WR,
	input wire logic [7:0] REG_RDATA,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic PC_LOAD,
	input wire logic [7:0] FLAGS_OUT
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	logic go;
	// an instruction is taken on this edge
	assign go = START && !BUSY;
	// per-opcode timing and flag effects, flag register read and idle hold
	AST_CCF: assert property (go && OPCODE == 8'hEF |->
		##4 DONE && FLAGS_OUT == ($past(FLAGS_OUT, 4) ^ 8'h80)) else $error("carry toggle bad");
	AST_ZFILL: assert property (go && OPCODE inside {8'hB0, 8'hB1} |->
		##4 DONE && FLAGS_OUT == $past(FLAGS_OUT, 4)) else $error("clear touched flags");
	AST_INV: assert property (go && OPCODE inside {8'h60, 8'h61} |->
		##4 DONE && !FLAGS_OUT[4] && (FLAGS_OUT & 8'h8C) == ($past(FLAGS_OUT, 4) & 8'h8C))
		else $error("invert flags bad");
	AST_CMP6: assert property (go && OPCODE inside {[8'hA3:8'hA6]} |->
		##1 !DONE [*5] ##1 DONE) else $error("compare length bad");
	AST_STEP: assert property (go && OPCODE inside {8'hC2, 8'hD2} |->
		##16 (DONE or (!DONE ##2 DONE))) else $error("step branch length bad");
	AST_STEP_FL: assert property (go && OPCODE inside {8'hC2, 8'hD2} |->
		##16 FLAGS_OUT == $past(FLAGS_OUT, 16)) else $error("step branch touched flags");
	AST_FL_READ: assert property (REG_RD && REG_ADDR == 8'hD5 && !BUSY && !DONE |=>
		REG_RDATA == $past(FLAGS_OUT)) else $error("flag register read bad");
	AST_IDLE: assert property (!BUSY && !START && !REG_WR |=> $stable(FLAGS_OUT))
		else $error("flags moved while idle");
	// main scenarios reached
	COV_BR: cover property (go && OPCODE == 8'hC2 ##18 DONE);
	COV_LOAD: cover property (PC_LOAD);
	COV_BCD: cover property (go && OPCODE == 8'h41 ##4 DONE);
endmodule
bind cba_exec cba_exec_asserts u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .START(START),
	.OPCODE(OPCODE), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR),
	.REG_RDATA(REG_RDATA), .BUSY(BUSY), .DONE(DONE), .PC_LOAD(PC_LOAD), .FLAGS_OUT(FLAGS_OUT));

// >>> verification/compare_clear_bcd_alu_ops_test.sv
module compare_clear_bcd_alu_ops_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK = 0, RESET_N = 0, START = 0, REG_WR = 0, REG_RD = 0;
	logic [7:0] OPCODE = 0, OPERAND1 = 0, OPERAND2 = 0, OPERAND3 = 0, REG_ADDR = 0, REG_WDATA = 0;
	logic [15:0] PC_NEXT = 0, PC_VALUE;
	logic [7:0] REG_RDATA, FLAGS_OUT;
	logic BUSY, DONE, PC_LOAD, ILLEGAL;
	int num_errors = 0, checks = 0, seed = 32'hf03e;
	logic [7:0] mem [256];
	logic [7:0] ops [14] = '{8'hEF, 8'hB0, 8'hB1, 8'h60, 8'h61, 8'hA2, 8'hA3, 8'hA4, 8'hA5,
		8'hA6, 8'hC2, 8'hD2, 8'h40, 8'h41};
	logic [7:0] x, y, a1, a2, ca, d, s, r, f, op, wh, wl;
	logic [15:0] pcn;
	logic pl, il, tk, ec;
	int n, ecyc, ad, bd, rv;
	cba_exec DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .START(START), .OPCODE(OPCODE),
		.OPERAND1(OPERAND1), .OPERAND2(OPERAND2), .OPERAND3(OPERAND3), .PC_NEXT(PC_NEXT),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .BUSY(BUSY), .DONE(DONE), .PC_LOAD(PC_LOAD),
		.PC_VALUE(PC_VALUE), .ILLEGAL(ILLEGAL), .FLAGS_OUT(FLAGS_OUT));
	always #25 CLOCK = ~CLOCK;
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// register port write, mirrored in the model
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		REG_ADDR <= a;
		REG_WDATA <= v;
		REG_WR <= 1'b1;
		mem[a] = v;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		@(posedge CLOCK);
	endtask
	// register port read, data checked in the following cycle
	task automatic rd(input logic [7:0] a);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		@(negedge CLOCK);
		chk(REG_RDATA, mem[a], "register");
		@(posedge CLOCK);
	endtask
	// issue one instruction and count cycles until done
	task automatic run(input logic [7:0] o, b1, b2, input logic [15:0] pc);
		OPCODE <= o;
		OPERAND1 <= b1;
		OPERAND2 <= b2;
		OPERAND3 <= b1 ^ b2;
		PC_NEXT <= pc;
		START <= 1'b1;
		@(posedge CLOCK);
		START <= 1'b0;
		pl = 1'b0;
		il = 1'b0;
		for (n = 1; n < 40; n++) begin
			@(negedge CLOCK);
			pl = pl | PC_LOAD;
			il = il | ILLEGAL;
			if (DONE === 1'b1) break;
			@(posedge CLOCK);
		end
		@(posedge CLOCK);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#400_000;
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		mem[8'hD5] = 8'h00;
		repeat (5) @(posedge CLOCK);
		RESET_N <= 1'b1;
		@(posedge CLOCK);
		rd(8'hD5);
		// pointer pools point into the data area
		for (int a = 0; a < 256; a++) begin
			f = 8'($random(seed));
			if (a < 64 || a >= 192) f = {2'b01, f[5:0]};
			if (a != 'hD5) wr(a[7:0], f);
		end
		$display("test register setup done");
		for (int i = 0; i < 84; i++) begin
			op = ops[i % 14];
			x = 8'($random(seed));
			y = 8'($random(seed));
			pcn = 16'($random(seed));
			wh = {4'hC, x[7:4]};
			wl = {4'hC, x[3:0]};
			wr(8'hD5, 8'($random(seed)) & 8'hFC);
			a1 = op[0] ? {2'b00, x[5:0]} : {2'b01, x[5:0]};
			a2 = (op inside {8'hA4, 8'hA5}) ? {2'b01, y[5:0]} : y;
			ca = op[0] ? mem[a1] : a1;
			if (op inside {8'hA4, 8'hA5}) ca = a2;
			if (op inside {8'hA2, 8'hA3, 8'hC2, 8'hD2}) begin
				a1 = x;
				ca = wh;
			end
			if (op == 8'hEF) ca = 8'hD5;
			d = (op inside {8'hC2, 8'hD2}) ? mem[wl] : mem[ca];
			if (pcn[0] && op == 8'hA6) a2 = d;
			if (pcn[0] && op inside {8'hC2, 8'hD2}) wr(mem[wh], d);
			case (op)
				8'hA2: s = mem[wl];
				8'hA3: s = mem[mem[wl]];
				8'hA4: s = mem[a1];
				8'hA5: s = mem[mem[a1]];
				8'hA6: s = a2;
				default: s = mem[mem[wh]];
			endcase
			// a genuine bcd sum or difference, flag d selects which
			if (op[7:4] == 4'h4) begin
				ad = {$random(seed)} % 100;
				bd = {$random(seed)} % 100;
				d = 8'(ad / 10 * 16 + ad % 10);
				s = 8'(bd / 10 * 16 + bd % 10);
				rv = x[7] ? (ad - bd + 100) % 100 : (ad + bd) % 100;
				ec = x[7] ? ad < bd : ad + bd > 99;
				f = mem[8'hD5] & 8'h73;
				f[7] = x[7] ? d < s : {1'b0, d} + s > 9'd255;
				f[3] = x[7];
				f[2] = x[7] ? d[3:0] < s[3:0] : {1'b0, d[3:0]} + s[3:0] > 5'd15;
				wr(ca, x[7] ? d - s : d + s);
				wr(8'hD5, f);
			end
			// reference model
			f = mem[8'hD5];
			tk = 1'b0;
			ecyc = 4;
			case (op)
				8'hEF: f[7] = ~f[7];
				8'hB0, 8'hB1: mem[ca] = 8'h00;
				8'h60, 8'h61: begin
					mem[ca] = ~mem[ca];
					f[4] = 1'b0;
				end
				8'hC2, 8'hD2: begin
					tk = (d == s) ^ op[4];
					ecyc = tk ? 18 : 16;
					mem[ca] = mem[ca] + 8'h01;
				end
				8'h40, 8'h41: begin
					mem[ca] = 8'(rv / 10 * 16 + rv % 10);
					f[7] = ec;
				end
				default: begin
					r = d - s;
					f[7] = s > d;
					f[4] = (d[7] != s[7]) && (r[7] != d[7]);
					ecyc = (op == 8'hA2) ? 4 : 6;
				end
			endcase
			if (op[7:4] inside {4'h4, 4'h6}) r = mem[ca];
			if (op[7:4] inside {4'h4, 4'h6, 4'hA}) f[6:5] = {r == 8'h00, r[7]};
			mem[8'hD5] = f;
			run(op, a1, a2, pcn);
			chk(16'(n), 16'(ecyc), "cycles");
			chk(FLAGS_OUT, f, "flags");
			chk(pl, tk, "branch");
			if (tk) chk(PC_VALUE, pcn + {{8{y[7]}}, y}, "target");
			rd(ca);
		end
		$display("test instructions done");
		// an unknown opcode ends at once and leaves the flags alone
		run(8'hFF, 8'h00, 8'h00, 16'h0000);
		chk(16'(n), 16'd1, "illegal cycles");
		chk(il, 1'b1, "illegal");
		chk(FLAGS_OUT, mem[8'hD5], "illegal flags");
		$display("test illegal opcode done");
		print_verdict();
	end
endmodule
